// ==== hw/qec_counter.sv ====
// Quadrature up/down counter channel with AXI4-Lite registers.
// Assumes encoder and trigger pins are already synchronous to aclk.

module qec_counter #(
  parameter int CW = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              phase_input_a,
  input  wire logic              phase_input_b,
  input  wire logic              external_clear_input,
  input  wire logic              capture_trigger1,
  output qec_pkg::qec_irq_s      irq_o
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [3:0]    unit_mode_r;
  logic [3:0]    timer_ctrl_r;
  logic [9:0]    edge_sel_r;
  logic [4:0]    filter_r;
  logic [2:0]    count_mode_r;
  logic [CW-1:0] cmp0_r, cmp1_r, cc0_r, cc1_r;
  logic [CW-1:0] cnt_r;
  logic          dir_r;        // 1 = down.

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  logic       aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic [31:0] wmask;

  // Address and data are latched separately so either may come first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= qec_pkg::RST_ZERO;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // Ready flags come from flops; each drops once its item is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r > qec_pkg::ADDR_CC1 || awaddr_r[1:0] != 2'h0)
                        ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; byte strobes honoured on the low lanes used.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_mode_r  <= 4'h0;
      timer_ctrl_r <= 4'h0;
      edge_sel_r   <= 10'h000;
      filter_r     <= 5'h00;
      count_mode_r <= qec_pkg::MODE_X4;
      cmp0_r       <= qec_pkg::CNT_MAX;
      cmp1_r       <= qec_pkg::CNT_MAX;
    end else if (wr_go) begin
      if (awaddr_r == qec_pkg::ADDR_UNIT_MODE) begin
        unit_mode_r <= (unit_mode_r & ~wmask[3:0]) | (wdata_r[3:0] & wmask[3:0]);
      end else if (awaddr_r == qec_pkg::ADDR_TIMER_CTRL) begin
        timer_ctrl_r <= (timer_ctrl_r & ~wmask[3:0]) | (wdata_r[3:0] & wmask[3:0]);
      end else if (awaddr_r == qec_pkg::ADDR_EDGE_SEL) begin
        edge_sel_r <= (edge_sel_r & ~wmask[9:0]) | (wdata_r[9:0] & wmask[9:0]);
      end else if (awaddr_r == qec_pkg::ADDR_FILTER) begin
        filter_r <= (filter_r & ~wmask[4:0]) | (wdata_r[4:0] & wmask[4:0]);
      end else if (awaddr_r == qec_pkg::ADDR_COUNT_MODE) begin
        count_mode_r <= (count_mode_r & ~wmask[2:0]) | (wdata_r[2:0] & wmask[2:0]);
      end else if (awaddr_r == qec_pkg::ADDR_CMP0) begin
        cmp0_r <= (cmp0_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
      end else if (awaddr_r == qec_pkg::ADDR_CMP1) begin
        cmp1_r <= (cmp1_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
      end
    end
  end

  // Read channel: one cycle from address accept to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= qec_pkg::RST_ZERO;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        if (s_axi_araddr == qec_pkg::ADDR_UNIT_MODE) begin
          s_axi_rdata <= {28'h0, unit_mode_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_TIMER_CTRL) begin
          s_axi_rdata <= {28'h0, timer_ctrl_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_EDGE_SEL) begin
          s_axi_rdata <= {22'h0, edge_sel_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_FILTER) begin
          s_axi_rdata <= {27'h0, filter_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_COUNT_MODE) begin
          s_axi_rdata <= {29'h0, count_mode_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_CMP0) begin
          s_axi_rdata <= {16'h0, cmp0_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_CMP1) begin
          s_axi_rdata <= {16'h0, cmp1_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_CC0) begin
          s_axi_rdata <= {16'h0, cc0_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_CC1) begin
          s_axi_rdata <= {16'h0, cc1_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_COUNTER) begin
          s_axi_rdata <= {16'h0, cnt_r};
        end else if (s_axi_araddr == qec_pkg::ADDR_STATE) begin
          s_axi_rdata <= {31'h0, dir_r};
        end else begin
          s_axi_rdata <= qec_pkg::RST_ZERO;
          s_axi_rresp <= 2'h2; // Unmapped address answers SLVERR.
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Input conditioning: inversion, shared noise filter, edge detect
  // ------------------------------------------------------------------
  // Pins: 0 phase A, 1 phase B (shared with trigger 0), 2 clear, 3 trigger 1.
  logic [3:0] raw_in;
  logic [3:0] filt_r, filt_d_r;
  logic [3:0] rise, fall;
  logic [2:0] filt_sel;
  assign filt_sel = filter_r[qec_pkg::NF_WIDTH_LSB +: 3];
  assign raw_in = {capture_trigger1, external_clear_input,
                   phase_input_b ^ filter_r[qec_pkg::NF_B_INV_BIT],
                   phase_input_a ^ filter_r[qec_pkg::NF_A_INV_BIT]};

  // One filter width applies to every pin of the channel; a level must
  // stay stable for one clock more than that width before it is accepted.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      logic [2:0] stab_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stab_r         <= 3'h0;
          filt_r[gi]     <= 1'b0;
          filt_d_r[gi]   <= 1'b0;
        end else begin
          filt_d_r[gi] <= filt_r[gi];
          if (raw_in[gi] == filt_r[gi]) begin
            stab_r <= 3'h0;
          end else if (stab_r >= filt_sel) begin
            filt_r[gi] <= raw_in[gi];
            stab_r     <= 3'h0;
          end else begin
            stab_r <= stab_r + 3'h1;
          end
        end
      end
      assign rise[gi] = filt_r[gi] & ~filt_d_r[gi];
      assign fall[gi] = ~filt_r[gi] & filt_d_r[gi];
    end
  endgenerate

  // Valid edge per edge-select pair.
  function automatic logic edge_ok(input logic [1:0] sel, input logic r, input logic f);
    edge_ok = (sel[0] & r) | (sel[1] & f);
  endfunction

  // ------------------------------------------------------------------
  // Count decision
  // ------------------------------------------------------------------
  logic a_ev, b_ev, step, step_dn, updown, x4;
  always_comb begin
    updown  = unit_mode_r[qec_pkg::UM_UPDOWN_BIT] & timer_ctrl_r[qec_pkg::TC_ENABLE_BIT];
    x4      = (count_mode_r == qec_pkg::MODE_X4);
    a_ev    = rise[0] | fall[0];
    b_ev    = rise[1] | fall[1];
    step    = 1'b0;
    step_dn = dir_r;
    if (!updown) begin
      step = 1'b0;
    end else if (x4) begin
      step = a_ev | b_ev;
      if (a_ev && b_ev) begin
        step_dn = dir_r;
      end else if (a_ev) begin
        step_dn = (filt_r[0] == filt_r[1]);
      end else if (b_ev) begin
        step_dn = (filt_r[0] != filt_r[1]);
      end
    end else if (count_mode_r == 3'h4) begin
      step    = edge_ok(edge_sel_r[qec_pkg::ES_A_LSB +: 2], rise[0], fall[0]);
      step_dn = filt_r[1];
    end else if (count_mode_r == 3'h5) begin
      step    = edge_ok(edge_sel_r[qec_pkg::ES_A_LSB +: 2], rise[0], fall[0]) ^
                edge_ok(edge_sel_r[qec_pkg::ES_B_LSB +: 2], rise[1], fall[1]);
      step_dn = ~edge_ok(edge_sel_r[qec_pkg::ES_A_LSB +: 2], rise[0], fall[0]);
    end else if (count_mode_r == 3'h6) begin
      step    = edge_ok(edge_sel_r[qec_pkg::ES_A_LSB +: 2], rise[0], fall[0]);
      step_dn = ~filt_r[1];
    end
  end

  // ------------------------------------------------------------------
  // Counter, clears, reload and event pulses
  // ------------------------------------------------------------------
  logic var_b, m0, m1, ext_clr, clr_a;
  assign var_b   = unit_mode_r[qec_pkg::UM_VARIANT_BIT];
  assign m0      = (cnt_r == cmp0_r);
  assign m1      = (cnt_r == cmp1_r);
  assign ext_clr = updown && !var_b && timer_ctrl_r[qec_pkg::TC_CLR_LO_BIT] &&
                   edge_ok(edge_sel_r[qec_pkg::ES_CLR_LSB +: 2], rise[2], fall[2]);
  assign clr_a   = timer_ctrl_r[qec_pkg::TC_CLR_HI_BIT]; // Compare-0 clear enable.

  // The match is judged on the value held before the step, so every action and pulse,
  // save the compare-0 pulse on a wrap from zero, lands on the count clock after the match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= qec_pkg::CNT_ZERO;
      irq_o <= '0;
    end else begin
      irq_o <= '0;
      if (ext_clr) begin
        cnt_r <= qec_pkg::CNT_ZERO;
      end else if (step) begin
        if (!var_b) begin
          if (!step_dn && m0 && clr_a) begin
            cnt_r <= qec_pkg::CNT_ZERO;
          end else if (step_dn && cnt_r == qec_pkg::CNT_ZERO &&
                       timer_ctrl_r[qec_pkg::TC_RELOAD_BIT]) begin
            cnt_r <= cmp0_r;
          end else if (step_dn) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
          // Without reload, wrapping from zero onto an all-ones compare 0 also matches.
          irq_o.cmp0 <= m0 || (step_dn && cnt_r == qec_pkg::CNT_ZERO &&
                        cmp0_r == qec_pkg::CNT_MAX &&
                        !timer_ctrl_r[qec_pkg::TC_RELOAD_BIT]);
          irq_o.cmp1 <= m1;
        end else begin
          if (!step_dn && m0) begin
            cnt_r <= qec_pkg::CNT_ZERO;
          end else if (step_dn && m1) begin
            cnt_r <= qec_pkg::CNT_ZERO;
          end else if (step_dn) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
          irq_o.cmp0 <= m0 && !step_dn;
          irq_o.cmp1 <= m1 && step_dn;
        end
        irq_o.ovf <= (cnt_r == qec_pkg::CNT_MAX) && !step_dn;
        irq_o.udf <= (cnt_r == qec_pkg::CNT_ZERO) && step_dn;
      end
      // Capture/compare channels; trigger 0 shares the phase B pin.
      if (unit_mode_r[qec_pkg::UM_CC0_CAP_BIT]) begin
        irq_o.cc0 <= edge_ok(edge_sel_r[qec_pkg::ES_T0_LSB +: 2], rise[1], fall[1]);
      end else begin
        irq_o.cc0 <= step && (cnt_r == cc0_r);
      end
      if (unit_mode_r[qec_pkg::UM_CC1_CAP_BIT]) begin
        irq_o.cc1 <= edge_ok(edge_sel_r[qec_pkg::ES_T1_LSB +: 2], rise[3], fall[3]);
      end else begin
        irq_o.cc1 <= step && (cnt_r == cc1_r);
      end
    end
  end

  // Capture registers latch on their trigger edge, or take a compare
  // value from software when in compare mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc0_r <= qec_pkg::CNT_MAX;
      cc1_r <= qec_pkg::CNT_MAX;
    end else begin
      if (unit_mode_r[qec_pkg::UM_CC0_CAP_BIT]) begin
        if (edge_ok(edge_sel_r[qec_pkg::ES_T0_LSB +: 2], rise[1], fall[1])) begin
          cc0_r <= cnt_r;
        end
      end else if (wr_go && awaddr_r == qec_pkg::ADDR_CC0) begin
        cc0_r <= (cc0_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
      end
      if (unit_mode_r[qec_pkg::UM_CC1_CAP_BIT]) begin
        if (edge_ok(edge_sel_r[qec_pkg::ES_T1_LSB +: 2], rise[3], fall[3])) begin
          cc1_r <= cnt_r;
        end
      end else if (wr_go && awaddr_r == qec_pkg::ADDR_CC1) begin
        cc1_r <= (cc1_r & ~wmask[CW-1:0]) | (wdata_r[CW-1:0] & wmask[CW-1:0]);
      end
    end
  end

  // Direction flag follows the decoded direction each clock, holding
  // when no count step happens; 1 means counting down.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_r <= 1'b0;
    end else if (step) begin
      dir_r <= step_dn;
    end
  end

endmodule // qec_counter

// ==== hw/qec_pkg.sv ====
// Package for the quadrature up/down counter channel: register map, field
// positions, reset values and shared types.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package qec_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_UNIT_MODE   = 8'h00; // timer_unit_mode_reg
  localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h04; // timer_control_reg
  localparam logic [7:0] ADDR_EDGE_SEL    = 8'h08; // edge_select_reg
  localparam logic [7:0] ADDR_FILTER      = 8'h0C; // noise_filter_reg
  localparam logic [7:0] ADDR_COUNT_MODE  = 8'h10; // count_mode_select
  localparam logic [7:0] ADDR_CMP0        = 8'h14;
  localparam logic [7:0] ADDR_CMP1        = 8'h18;
  localparam logic [7:0] ADDR_CC0         = 8'h1C;
  localparam logic [7:0] ADDR_CC1         = 8'h20;
  localparam logic [7:0] ADDR_COUNTER     = 8'h24; // encoder_counter, read only
  localparam logic [7:0] ADDR_STATE       = 8'h28; // counter_state_reg, read only

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int UM_UPDOWN_BIT   = 0;  // updown_mode_bit
  localparam int UM_VARIANT_BIT  = 1;  // clear_variant_select
  localparam int UM_CC0_CAP_BIT  = 2;  // 1: capcmp_reg0 captures
  localparam int UM_CC1_CAP_BIT  = 3;
  localparam int TC_ENABLE_BIT   = 0;  // count enable
  localparam int TC_CLR_LO_BIT   = 1;  // clear_source_sel_lo
  localparam int TC_CLR_HI_BIT   = 2;  // clear_source_sel_hi
  localparam int TC_RELOAD_BIT   = 3;  // reload_enable
  localparam int NF_A_INV_BIT    = 0;  // phase_a_invert
  localparam int NF_B_INV_BIT    = 1;  // phase_b_invert
  localparam int NF_WIDTH_LSB    = 2;  // filter width sel 0/1/f
  localparam int ST_DIR_BIT      = 0;  // direction_flag

  // Edge select: two bits per input, 0 none, 1 rise, 2 fall, 3 both.
  localparam int ES_A_LSB   = 0;
  localparam int ES_B_LSB   = 2;
  localparam int ES_CLR_LSB = 4;
  localparam int ES_T0_LSB  = 6;
  localparam int ES_T1_LSB  = 8;

  localparam logic [2:0] MODE_X4 = 3'h7;

  // Clear source codes in variant A.
  localparam logic [1:0] CLRSRC_EXT  = 2'h1;
  localparam logic [1:0] CLRSRC_CMP  = 2'h2;
  localparam logic [1:0] CLRSRC_BOTH = 2'h3;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [2:0]  FILT_MAX_SEL = 3'h7;

  // Event pulses of the channel.
  typedef struct packed {
    logic cmp0;
    logic cmp1;
    logic cc0;
    logic cc1;
    logic ovf;
    logic udf;
  } qec_irq_s;

  typedef enum logic [1:0] {
    QEC_BUS_IDLE = 2'b00,
    QEC_BUS_RESP = 2'b01
  } qec_bus_e;

endpackage

// ==== verification/qec_counter_checker.sv ====
// Port-level checker for the quadrature counter channel.
// Assumes it is bound into qec_counter and sees only that module's ports.
module qec_counter_checker (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              phase_input_a,
  input wire logic              phase_input_b,
  input wire qec_pkg::qec_irq_s irq_o
);
  logic [1:0] prev_r;
  logic [3:0] quiet_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since a phase last moved; count events must follow a recent edge.
  always_ff @(posedge aclk) begin
    prev_r <= {phase_input_a, phase_input_b};
    if (!aresetn || prev_r != {phase_input_a, phase_input_b}) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  a_count_needs_edge: assert property ((irq_o.cmp0 || irq_o.cmp1 || irq_o.ovf || irq_o.udf)
    |-> quiet_r < 4'hE) else $error("count event without phase edge");
  a_ovf_udf_apart: assert property (!(irq_o.ovf && irq_o.udf))
    else $error("overflow and underflow together");
  a_wrap_single: assert property ((irq_o.ovf || irq_o.udf) |=> !(irq_o.ovf || irq_o.udf))
    else $error("wrap event longer than one cycle");
  a_reset_quiet: assert property (!$past(aresetn) |-> irq_o == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ready_pending: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule // qec_counter_checker

bind qec_counter qec_counter_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .phase_input_a, .phase_input_b, .irq_o);

// ==== verification/qec_encoder.sv ====
// Incremental encoder model driving the two phase inputs.
// Assumes its caller runs in a process clocked by aclk.
module qec_encoder (
  input  wire logic aclk,
  output logic      phase_a,
  output logic      phase_b
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos = 0;
  initial {phase_a, phase_b} = 2'b00;
  // Delta 1 steps up, 3 down, 2 flips both phases at one edge.
  task automatic move(input int delta, input int hold);
    logic [1:0] seq [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    pos = (pos + delta) % 4;
    @(posedge aclk);
    {phase_a, phase_b} <= seq[pos];
    repeat (hold) @(posedge aclk);
  endtask
endmodule // qec_encoder

// ==== verification/tb_quadrature_updown_counter.sv ====
// Self-checking bench for the quadrature counter channel.
// Assumes the encoder model and the bound checker are compiled with it.
module tb_quadrature_updown_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic phase_input_a, phase_input_b, external_clear_input, capture_trigger1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  qec_pkg::qec_irq_s irq_o;
  int errors, checks_done, cnt, dir, cmp0, cmp1, cc0, cc1, varb, clrcmp, reload, cap1;
  int exp_irq [6];
  int seen_irq [6];
  qec_counter uut (.*);
  qec_encoder enc (.aclk, .phase_a(phase_input_a), .phase_b(phase_input_b));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Event pulses are tallied so that counts, not timing, are compared.
  always @(posedge aclk) begin
    if (aresetn) for (int i = 0; i < 6; i++) seen_irq[i] += (irq_o[i] === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Address and data are offered together and each is dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask
  task automatic verify();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(qec_pkg::ADDR_COUNTER, d, r);
    check(d, cnt);
    axi_read(qec_pkg::ADDR_STATE, d, r);
    check(d[0], dir);
    for (int i = 0; i < 6; i++) check(seen_irq[i], exp_irq[i]);
  endtask
  task automatic cfg(input int um, input int ctl, input int c0, input int c1);
    varb = um[1];
    cap1 = um[3];
    clrcmp = ctl[2];
    reload = ctl[3];
    cmp0 = c0;
    cmp1 = c1;
    axi_write(qec_pkg::ADDR_CMP0, c0, 2'h0);
    axi_write(qec_pkg::ADDR_CMP1, c1, 2'h0);
    axi_write(qec_pkg::ADDR_UNIT_MODE, um, 2'h0);
    axi_write(qec_pkg::ADDR_TIMER_CTRL, ctl, 2'h0);
  endtask
  // Reference model: one count step judged on the value before the step.
  task automatic step(input logic d);
    int pre;
    int nx;
    pre = cnt;
    nx = d ? (pre + 65535) % 65536 : (pre + 1) % 65536;
    if (!d && pre == 65535) exp_irq[1]++;
    if (d && pre == 0) begin
      exp_irq[0]++;
      if (reload && !varb) nx = cmp0;
      else if (cmp0 == 65535 && !varb) exp_irq[5]++;
    end
    if (pre == cmp0 && (!varb || !d)) begin
      exp_irq[5]++;
      if (!d && (varb || clrcmp)) nx = 0;
    end
    if (pre == cmp1 && (!varb || d)) begin
      exp_irq[4]++;
      if (varb) nx = 0;
    end
    if (pre == cc0) exp_irq[3]++;
    if (!cap1 && pre == cc1) exp_irq[2]++;
    cnt = nx;
    dir = d;
    enc.move(d ? 3 : 1, 4 + $urandom % 5);
  endtask
  task automatic run(input int n, input logic [31:0] pat);
    for (int i = 0; i < n; i++) step(pat[i]);
    verify();
  endtask
  task automatic pulse(input logic clr);
    @(posedge aclk);
    external_clear_input <= clr;
    capture_trigger1 <= !clr;
    repeat (4) @(posedge aclk);
    external_clear_input <= 1'b0;
    capture_trigger1 <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  // A hang counts as a mismatch and closes the run.
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {external_clear_input, capture_trigger1, aresetn} = '0;
    void'($urandom(32'h3f227ada));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    verify();
    axi_read(qec_pkg::ADDR_COUNT_MODE, d, r);
    check(d, qec_pkg::MODE_X4);
    axi_read(8'h40, d, r);
    check(r, 2'h2);
    axi_write(qec_pkg::ADDR_COUNTER, 32'h1, 2'h2);
    $display("test 1 done");
    cc0 = 3;
    cc1 = 16'h7777;
    axi_write(qec_pkg::ADDR_CC0, cc0, 2'h0);
    axi_write(qec_pkg::ADDR_CC1, cc1, 2'h0);
    axi_write(qec_pkg::ADDR_EDGE_SEL, 32'h0, 2'h0);
    axi_write(qec_pkg::ADDR_FILTER, 32'h0, 2'h0);
    cfg(1, 1, 16'h7777, 16'h7777);
    run(8, 32'h0);
    run(3, 32'h7);
    $display("test 2 done");
    cfg(1, 5, 6, 16'h7777);
    run(4, 32'hC);
    cfg(1, 13, 6, 16'h7777);
    run(3, 32'h4);
    cfg(1, 1, 16'hFFFF, 16'h7777);
    run(7, 32'h7F);
    $display("test 3 done");
    cfg(3, 1, 8, 4);
    run(17, 32'h0001_8000);
    $display("test 4 done");
    axi_write(qec_pkg::ADDR_EDGE_SEL, 32'h110, 2'h0);
    cfg(9, 1, 8, 4);
    run(3, 32'h0);
    pulse(1'b0);
    exp_irq[2]++;
    axi_read(qec_pkg::ADDR_CC1, d, r);
    check(d, cnt);
    axi_write(qec_pkg::ADDR_TIMER_CTRL, 32'h3, 2'h0);
    pulse(1'b1);
    cnt = 0;
    verify();
    $display("test 5 done");
    run(1, 32'h1);
    cnt = cnt - 1;
    enc.move(2, 8);
    axi_read(qec_pkg::ADDR_STATE, d, r);
    check(d[0], dir);
    verify();
    $display("test 6 done");
    conclude();
  end
endmodule // tb_quadrature_updown_counter
